// [dv/bcs_host.sv]
// Host register bus master model
`timescale 1ns/1ps
module bcs_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One bus cycle; each signal set once per edge, so calls may follow with no gap
  task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
endmodule // bcs_host

// [dv/testbench.sv]
// Self-checking bench for buffer channel select
`timescale 1ns/1ps
module testbench;
  import bcs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ctrl, sts, sample_sets = 8'h00;
  logic reg_wr, reg_rd, code_bad, temp_en, adc_en, rd_p = 1'b0;
  logic [1:0] wr_p = 2'b00, buf_mode;
  logic [4:0] chan_sel;
  logic [2:0] entries_per_set;
  logic [11:0] entry_target;
  logic [22:0] e, got_sel;
  logic [7:0] q_rd[$];
  logic [22:0] q_sel[$];
  int n_mismatch = 0, tests_run = 0, cycles = 0, seed = 32'h98f0;
  always #2.5 core_clk = ~core_clk;
  bcs_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  bcs_buffer_channel_select dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .sample_sets(sample_sets),
    .reg_rdata(reg_rdata), .chan_sel(chan_sel), .buf_mode(buf_mode),
    .entry_target(entry_target), .entries_per_set(entries_per_set), .code_bad(code_bad));
  // Expected {bad, channels, per set, target, mode}; extras count only when enabled
  function automatic logic [22:0] exp_sel(logic [7:0] c, logic [7:0] ss);
    logic [3:0] k;
    logic [4:0] ch;
    logic [2:0] n;
    k = c[6:3];
    ch = 5'h00;
    if (k < 4'hC) begin
      ch[2:0] = (k[1:0] == 2'h0) ? 3'h7 : 3'h1 << (k[1:0] - 2'h1);
      ch[3] = (k[3:2] == 2'h1) && temp_en;
      ch[4] = (k[3:2] == 2'h2) && adc_en;
    end
    n = 3'($countones(ch));
    return {k >= 4'hC, ch, n, 12'({c[2], ss}) * 12'(n), c[1:0]};
  endfunction
  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_sel(logic [22:0] got, logic [22:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t selection %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    rd_p <= reg_rd;
    wr_p <= {wr_p[0], reg_wr && reg_addr == BUF_CTRL_ADDR};
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  assign got_sel = {code_bad, chan_sel, entries_per_set, entry_target, buf_mode};
  // Settled at the falling edge; results leave the queues oldest first
  always @(negedge core_clk) begin
    if (rd_p) chk8(reg_rdata, q_rd.pop_front());
    if (wr_p[1]) chk_sel(got_sel, q_sel.pop_front());
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    q_rd.push_back(BUF_CTRL_RESET);
    host.op(1'b0, 1'b1, BUF_CTRL_ADDR, 8'h00);
    q_rd.push_back(8'h00);
    host.op(1'b0, 1'b1, 8'h55, 8'h00);
    for (int i = 0; i < 64; i++) begin
      if (i[3:0] == 4'h0) begin
        temp_en = i[4];
        adc_en = i[5];
        host.op(1'b1, 1'b0, TEMP_CFG_ADDR, {7'h00, temp_en});
        host.op(1'b1, 1'b0, ADC_CTRL_ADDR, {7'h00, adc_en});
        q_rd.push_back({7'h00, temp_en});
        host.op(1'b0, 1'b1, TEMP_CFG_ADDR, 8'h00);
      end
      // Code 0010 with extras enabled is left open, so only tried bare
      if (i[3:0] != 4'h2 || i < 16) begin
        // First pass is the fixed two-set xyz case, the rest step the code with random low bits and sets
        ctrl = {1'b0, i[3:0], (i == 0) ? 3'h0 : 3'($random(seed))};
        sample_sets <= (i == 0) ? 8'h02 : 8'($random(seed));
        host.op(1'b1, 1'b0, BUF_CTRL_ADDR, ctrl);
        e = exp_sel(ctrl, sample_sets);
        q_sel.push_back(e);
        q_rd.push_back(ctrl);
        host.op(1'b0, 1'b1, BUF_CTRL_ADDR, 8'h00);
        sts = {e[22], e[16:14], e[21:18]};
        q_rd.push_back(sts);
        host.op(1'b0, 1'b1, STATUS_ADDR, 8'h00);
        host.op(1'b0, 1'b0, 8'h00, 8'h00);
      end
    end
    repeat (4) host.op(1'b0, 1'b0, 8'h00, 8'h00);
    // Results never seen count against the run
    if (q_rd.size() != 0 || q_sel.size() != 0) n_mismatch++;
    print_verdict();
  end
endmodule // testbench

// [include/bcs_pkg.sv]
// Package for the buffer channel select block
package bcs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] BUF_CTRL_ADDR = 8'h28;
  localparam logic [7:0] BUF_CTRL_RESET = 8'h00;
  localparam logic [7:0] TEMP_CFG_ADDR = 8'h3D;
  localparam logic [7:0] ADC_CTRL_ADDR = 8'h3C;
  localparam logic [7:0] STATUS_ADDR = 8'h2A;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int TEMP_EN_BIT = 0;
  localparam int ADC_EN_BIT = 0;
  localparam int CHAN_LSB = 3;
  localparam int CHAN_W = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int SMPL_MSB_BIT = 2;
  localparam int DEPTH_W = 9;
  localparam logic [3:0] CODE_XYZ = 4'h0;
  localparam logic [3:0] CODE_X = 4'h1;
  localparam logic [3:0] CODE_Y = 4'h2;
  localparam logic [3:0] CODE_Z = 4'h3;
  localparam logic [3:0] CODE_XYZ_T = 4'h4;
  localparam logic [3:0] CODE_X_T = 4'h5;
  localparam logic [3:0] CODE_Y_T = 4'h6;
  localparam logic [3:0] CODE_Z_T = 4'h7;
  localparam logic [3:0] CODE_XYZ_A = 4'h8;
  localparam logic [3:0] CODE_X_A = 4'h9;
  localparam logic [3:0] CODE_Y_A = 4'hA;
  localparam logic [3:0] CODE_Z_A = 4'hB;
  localparam logic [4:0] CH_NONE = 5'h00;
endpackage

// [rtl/bcs_buffer_channel_select.sv]
// Buffer control register and channel selection for the sample buffer
`timescale 1ns/1ps
// Functional notes
// - Buffer control register at 0x28, resets to 0x00.
// - Code 0000 converts x, y and z; this is the default.
// - Code 0001 converts x axis only.
// - Code 0010 stores y axis only, never temperature or converter.
// - Code 0011 converts one axis; taken as z, needs confirmation.
// - Code 0100 converts all three axes plus temperature.
// - Codes 0101, 0110, 0111 select x, y, z plus temperature.
// - Code 1000 converts all three axes plus converter sample.
// - Code 1001 is x plus converter; 1011 is z plus converter.
// - Each selected channel is a separate entry; 2 sets of xyz is 6.
module bcs_buffer_channel_select #(
  parameter int DEPTH_WIDTH = bcs_pkg::DEPTH_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [bcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] sample_sets,
  output logic [bcs_pkg::DATA_W-1:0] reg_rdata,
  output logic [4:0] chan_sel,
  output logic [1:0] buf_mode,
  output logic [DEPTH_WIDTH+2:0] entry_target,
  output logic [2:0] entries_per_set,
  output logic code_bad
);
  import bcs_pkg::*;
  logic rst_meta_b;
  logic rst_sync_b;
  logic [7:0] ctrl_reg;
  logic [7:0] temp_cfg_reg;
  logic [7:0] adc_ctrl_reg;
  logic [4:0] sel_next;
  logic [2:0] per_next;
  logic bad_next;
  logic [DEPTH_WIDTH-1:0] depth;
  logic [CHAN_W-1:0] code_now;
  logic temp_on;
  logic adc_on;

  // Reset released through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_reg <= BUF_CTRL_RESET;
      temp_cfg_reg <= CFG_RESET;
      adc_ctrl_reg <= CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == BUF_CTRL_ADDR) ctrl_reg <= reg_wdata;
      if (reg_addr == TEMP_CFG_ADDR) temp_cfg_reg <= reg_wdata;
      if (reg_addr == ADC_CTRL_ADDR) adc_ctrl_reg <= reg_wdata;
    end
  end

  // Field views shared by the decoder and the checks below
  assign code_now = ctrl_reg[CHAN_LSB +: CHAN_W];
  assign temp_on = temp_cfg_reg[TEMP_EN_BIT];
  assign adc_on = adc_ctrl_reg[ADC_EN_BIT];

  bcs_decode u_decode (
    .code(code_now),
    .temp_en(temp_on),
    .adc_en(adc_on),
    .chan_sel(sel_next),
    .per_set(per_next),
    .code_bad(bad_next)
  );

  // Sample-set depth: 8 low bits external, bit 8 from control
  assign depth = DEPTH_WIDTH'({ctrl_reg[SMPL_MSB_BIT], sample_sets});

  // Registered outputs; forbidden codes select nothing
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      chan_sel <= CH_NONE;
      entries_per_set <= 3'h0;
      code_bad <= 1'b0;
      buf_mode <= 2'h0;
      entry_target <= '0;
    end else begin
      chan_sel <= sel_next;
      entries_per_set <= per_next;
      code_bad <= bad_next;
      buf_mode <= ctrl_reg[MODE_LSB +: MODE_W];
      // Operands widened first so 511 sets of four channels cannot wrap
      entry_target <= (DEPTH_WIDTH+3)'(depth) * (DEPTH_WIDTH+3)'(per_next);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        BUF_CTRL_ADDR: reg_rdata <= ctrl_reg;
        TEMP_CFG_ADDR: reg_rdata <= temp_cfg_reg;
        ADC_CTRL_ADDR: reg_rdata <= adc_ctrl_reg;
        STATUS_ADDR: reg_rdata <= {code_bad, entries_per_set, 4'(chan_sel[4:1])};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Reset value check, then selection checks: decode of the code seen one edge earlier
  a_reset_value: assert property (@(posedge core_clk)
    $rose(rst_sync_b) |-> ctrl_reg == BUF_CTRL_RESET)
    else $error("control not reset to zero");
  a_default_xyz: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_XYZ |=> chan_sel[2:0] == 3'h7)
    else $error("default code not xyz");
  a_x_only: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_X |=> chan_sel == 5'h01)
    else $error("code 1 not x only");
  a_y_only: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Y |=> chan_sel[2:0] == 3'h2)
    else $error("code 2 not y only");
  a_z_only: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Z |=> chan_sel == 5'h04)
    else $error("code 3 not z only");
  a_temp_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_XYZ_T && temp_on |=> chan_sel == 5'h0F)
    else $error("xyz with temperature wrong");
  a_temp_off: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_XYZ_T && !temp_on |=> chan_sel == 5'h07)
    else $error("temperature stored while disabled");
  a_single_temp: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Y_T && !temp_on |=> chan_sel == 5'h02)
    else $error("y temperature code wrong");
  a_x_temp: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_X_T && temp_on |=> chan_sel == 5'h09)
    else $error("x temperature code wrong");
  a_y_temp: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Y_T && temp_on |=> chan_sel == 5'h0A)
    else $error("y with temperature wrong");
  a_z_temp: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Z_T && temp_on |=> chan_sel == 5'h0C)
    else $error("z temperature code wrong");
  a_adc_xyz: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_XYZ_A && adc_on |=> chan_sel == 5'h17)
    else $error("xyz with converter wrong");
  a_adc_off: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now >= CODE_XYZ_A && code_now <= CODE_Z_A && !adc_on |=> !chan_sel[4])
    else $error("converter stored while disabled");
  a_adc_single: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Z_A && adc_on |=> chan_sel == 5'h14)
    else $error("z with converter wrong");
  a_x_adc: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_X_A && adc_on |=> chan_sel == 5'h11)
    else $error("x with converter wrong");
  a_adc_y: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Y_A && adc_on |=> chan_sel == 5'h12)
    else $error("y with converter wrong");
  a_y_adc_off: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == CODE_Y_A && !adc_on |=> chan_sel == 5'h02)
    else $error("y converter code wrong");

  // Upper codes select nothing, so a stray write cannot fill the buffer
  sequence s_forbidden;
    code_now > CODE_Z_A;
  endsequence
  a_forbidden_code: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    s_forbidden |=> code_bad && chan_sel == CH_NONE && entries_per_set == 3'h0)
    else $error("forbidden code selected channels");
  a_forbidden_last: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now == 4'hF |=> code_bad && entry_target == '0)
    else $error("code 15 not flagged");
  a_legal_code: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    code_now <= CODE_Z_A |=> !code_bad)
    else $error("legal code flagged");

  // Write lands on the next edge, the selection one edge after that
  sequence s_ctrl_write;
    reg_wr && reg_addr == BUF_CTRL_ADDR;
  endsequence
  sequence s_ctrl_landed;
    ctrl_reg == $past(reg_wdata);
  endsequence
  sequence s_x_write;
    s_ctrl_write ##0 reg_wdata[CHAN_LSB +: CHAN_W] == CODE_X;
  endsequence
  sequence s_x_selected;
    ##1 chan_sel == 5'h01;
  endsequence
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    s_ctrl_write |=> s_ctrl_landed)
    else $error("control write lost");
  a_write_select: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    s_x_write |=> s_x_selected)
    else $error("x code write not selected");

  // Entry counts follow the depth with one edge of lag
  a_entry_count: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    $stable(ctrl_reg) && code_now == CODE_XYZ && ctrl_reg[SMPL_MSB_BIT] == 1'b0
      && sample_sets == 8'h02 |=> entry_target == 12'h006)
    else $error("two xyz sets not six entries");
  a_entry_product: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    $stable(ctrl_reg) && $stable(sample_sets) |-> entry_target
      == (DEPTH_WIDTH+3)'(depth) * (DEPTH_WIDTH+3)'(entries_per_set))
    else $error("entries not sets times channels");

  // Read port: data for one cycle only, zero otherwise
  a_read_ctrl: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    reg_rd && reg_addr == BUF_CTRL_ADDR |=> reg_rdata == $past(ctrl_reg))
    else $error("control read back wrong");
  a_read_idle: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
endmodule // bcs_buffer_channel_select

// [rtl/bcs_decode.sv]
// Channel code decoder: axis, temperature and converter selects
`timescale 1ns/1ps
module bcs_decode (
  input wire logic [3:0] code,
  input wire logic temp_en,
  input wire logic adc_en,
  output logic [4:0] chan_sel,
  output logic [2:0] per_set,
  output logic code_bad
);
  import bcs_pkg::*;
  logic [2:0] axes;
  logic want_t;
  logic want_a;

  always_comb begin
    axes = 3'h0;
    want_t = 1'b0;
    want_a = 1'b0;
    code_bad = 1'b0;
    unique case (code)
      CODE_XYZ: axes = 3'h7;
      CODE_X: axes = 3'h1;
      CODE_Y: axes = 3'h2;
      CODE_Z: axes = 3'h4;
      CODE_XYZ_T: begin
        axes = 3'h7;
        want_t = 1'b1;
      end
      CODE_X_T, CODE_Y_T, CODE_Z_T: begin
        axes = 3'h1 << (code - CODE_X_T);
        want_t = 1'b1;
      end
      CODE_XYZ_A: begin
        axes = 3'h7;
        want_a = 1'b1;
      end
      CODE_X_A, CODE_Z_A: begin
        axes = (code == CODE_X_A) ? 3'h1 : 3'h4;
        want_a = 1'b1;
      end
      CODE_Y_A: begin
        axes = 3'h2;
        want_a = 1'b1;
      end
      default: code_bad = 1'b1; // Forbidden codes store nothing
    endcase
  end

  // Extra samples need their own enables, else only the axes are measured
  always_comb begin
    chan_sel = {want_a & adc_en, want_t & temp_en, axes};
    per_set = 3'(chan_sel[0]) + 3'(chan_sel[1]) + 3'(chan_sel[2])
      + 3'(chan_sel[3]) + 3'(chan_sel[4]);
  end
endmodule // bcs_decode
